// [logic/card_strobe_pkg.sv]
// constants and types shared by the card strobe sequencer
package card_strobe_pkg;
  localparam int  CLOCK_MHZ       = 100;
  localparam int  SETUP_NS        = 30;   // address/enable setup before a strobe
  localparam int  STROBE_NS       = 100;  // least strobe width
  localparam int  HOLD_NS         = 20;   // enables held after strobe release
  localparam int  SETUP_CYCLES    = (SETUP_NS * CLOCK_MHZ + 999) / 1000;
  localparam int  STROBE_CYCLES   = (STROBE_NS * CLOCK_MHZ + 999) / 1000;
  localparam int  HOLD_CYCLES     = (HOLD_NS * CLOCK_MHZ + 999) / 1000;
  localparam int  COUNT_W         = 8;
  // fields of the request word latched at take
  localparam int  LAT_W           = 4;
  localparam int  LAT_ATTR        = 3;
  localparam int  LAT_EVEN        = 2;
  localparam int  LAT_ODD         = 1;
  localparam int  LAT_LAST        = 0;
  localparam logic STROBE_IDLE    = 1'b1;  // all card strobes are active low
  localparam logic STROBE_ACTIVE  = 1'b0;

  // cycle kinds requested by the host side
  typedef enum logic [2:0] {
    CYC_MEM_READ  = 3'h0,
    CYC_MEM_WRITE = 3'h1,
    CYC_IO_READ   = 3'h2,
    CYC_IO_WRITE  = 3'h3,
    CYC_DMA_IN    = 3'h4,  // card to host memory
    CYC_DMA_OUT   = 3'h5   // host memory to card
  } cycle_kind_t;

  // sequencer states, gray along idle-setup-strobe-hold
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETUP  = 2'b01,
    ST_STROBE = 2'b11,
    ST_HOLD   = 2'b10
  } strobe_state_t;
endpackage : card_strobe_pkg

// [logic/pin_sync.sv]
// two-flop synchroniser for a group of card input pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input  wire logic             clock,   // system clock
  input  wire logic             rst,     // async reset, high
  input  wire logic [WIDTH-1:0] pin_in,  // raw pins
  output logic      [WIDTH-1:0] pin_out  // synchronised pins
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_out;

  // first stage feeds only the second
  always_comb begin
    next_meta = pin_in;
    next_out  = meta;
  end

  // idle pins reset to their deasserted level
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta    <= INIT;
      pin_out <= INIT;
    end else begin
      meta    <= next_meta;
      pin_out <= next_out;
    end
  end
endmodule : pin_sync

// [logic/card_strobe_ctrl.sv]
// 16-bit card control strobe sequencer: enables, read/write strobes, dma reuse
// What this block does
// - even byte access asserts the even card enable
// - odd byte access asserts odd enable; both enables make a word
// - host io read cycles assert the io read strobe
// - dma card-to-memory transfers use io read strobe as write strobe
// - host io write cycles drive io write strobe low
// - dma memory-to-card transfers use io write strobe as strobe
// - host memory read cycles drive output enable low
// - dma write operation asserts output enable as terminal count
// - ready/irq pin is ready only in memory-only mode, else irq
// - dma read operation asserts write enable as terminal count
// - attribute select acts as dma ack alongside the dma strobes
// - card wait extends the cycle; completion is held off meanwhile
`timescale 1ns/1ps
module card_strobe_ctrl
  import card_strobe_pkg::*;
#(
  parameter int SETUP_CNT  = SETUP_CYCLES,
  parameter int STROBE_CNT = STROBE_CYCLES,
  parameter int HOLD_CNT   = HOLD_CYCLES
) (
  input  wire logic        clock,            // 100 MHz system clock
  input  wire logic        rst,              // async reset, high
  // host side request
  input  wire logic        req_valid,        // start a card cycle
  output logic             req_ready,        // sequencer idle, request taken
  input  wire cycle_kind_t req_kind,         // kind of cycle
  input  wire logic        req_attr,         // attribute/io space select
  input  wire logic        req_even,         // even byte lane wanted
  input  wire logic        req_odd,          // odd byte lane wanted
  input  wire logic        req_last,         // dma terminal count beat
  output logic             done,             // one-cycle cycle complete pulse
  output logic             done_input_ack,   // input ack seen during io read
  input  wire logic        memory_only_mode, // socket configured memory-only
  input  wire logic        dma_enable,       // dma from card configured
  // card status back to host side
  output logic             card_ready,       // ready level in memory-only mode
  output logic             card_irq,         // irq request level in io mode
  output logic             dma_request,      // dma request from card
  // card pins, active low except the ready level on ready_irq_pin
  output logic             card_enable_even_n, // even byte enable
  output logic             card_enable_odd_n,  // odd byte enable
  output logic             io_read_strobe_n,   // io read / dma write strobe
  output logic             io_write_strobe_n,  // io write / dma read strobe
  output logic             output_enable_n,    // memory read / dma count end
  output logic             write_enable_n,     // memory write / dma count end
  output logic             attr_select_n,      // attribute select / dma ack
  input  wire logic        input_ack_n,        // input ack / dma request pin
  input  wire logic        ready_irq_pin,      // ready or irq (low) pin
  input  wire logic        wait_n              // cycle wait from card
);
  ////////////////////////////////////////////////////////////////
  // card inputs cross into the clock domain first
  logic       ack_s;
  logic       rdy_s;
  logic       wait_s;

  pin_sync #(.WIDTH(3), .INIT({3{STROBE_IDLE}})) u_sync (
    .clock   (clock),
    .rst     (rst),
    .pin_in  ({input_ack_n, ready_irq_pin, wait_n}),
    .pin_out ({ack_s, rdy_s, wait_s})
  );

  // pin role depends on socket mode
  always_comb begin
    card_ready  = memory_only_mode & rdy_s;
    card_irq    = ~memory_only_mode & ~rdy_s;
    dma_request = dma_enable & ~ack_s;
  end

  ////////////////////////////////////////////////////////////////
  // sequencer state
  strobe_state_t    state;
  strobe_state_t    next_state;
  logic [COUNT_W-1:0] count;
  logic [COUNT_W-1:0] next_count;
  cycle_kind_t      kind;
  cycle_kind_t      next_kind;
  logic [LAT_W-1:0] lat;        // attr, even, odd, last
  logic [LAT_W-1:0] next_lat;
  logic             ack_seen;
  logic             next_ack_seen;
  logic             next_done;
  logic             next_done_ack;

  // request held for the whole cycle so pins cannot glitch mid-cycle
  always_comb begin
    next_state    = state;
    next_count    = count;
    next_kind     = kind;
    next_lat      = lat;
    next_ack_seen = ack_seen;
    next_done     = 1'b0;
    next_done_ack = 1'b0;
    case (state)
      ST_IDLE: begin
        if (req_valid) begin
          next_state    = ST_SETUP;
          next_kind     = req_kind;
          next_lat      = {req_attr, req_even, req_odd, req_last};
          next_count    = COUNT_W'(SETUP_CNT - 1);
          next_ack_seen = 1'b0;
        end
      end
      ST_SETUP: begin
        if (count == '0) begin
          next_state = ST_STROBE;
          next_count = COUNT_W'(STROBE_CNT - 1);
        end else begin
          next_count = count - 1'b1;
        end
      end
      ST_STROBE: begin
        if (kind == CYC_IO_READ && !ack_s) begin
          next_ack_seen = 1'b1;
        end
        if (count != '0) begin
          next_count = count - 1'b1;
        end else if (wait_s) begin
          next_state = ST_HOLD;
          next_count = COUNT_W'(HOLD_CNT - 1);
        end
      end
      ST_HOLD: begin
        if (count == '0) begin
          next_state    = ST_IDLE;
          next_done     = 1'b1;
          next_done_ack = ack_seen;
        end else begin
          next_count = count - 1'b1;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // state registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state          <= ST_IDLE;
      count          <= '0;
      kind           <= CYC_MEM_READ;
      lat            <= '0;
      ack_seen       <= 1'b0;
      done           <= 1'b0;
      done_input_ack <= 1'b0;
    end else begin
      state          <= next_state;
      count          <= next_count;
      kind           <= next_kind;
      lat            <= next_lat;
      ack_seen       <= next_ack_seen;
      done           <= next_done;
      done_input_ack <= next_done_ack;
    end
  end

  assign req_ready = (state == ST_IDLE);

  ////////////////////////////////////////////////////////////////
  // pin values; one read or write strobe per cycle kind keeps read and write apart, dma terminal count adds oe or we
  logic in_cycle;
  logic strobing;
  logic is_dma;
  logic p_even;
  logic p_odd;
  logic p_io_read;
  logic p_io_write;
  logic p_oe;
  logic p_we;
  logic p_attr;

  always_comb begin
    in_cycle = (state != ST_IDLE);
    strobing = (state == ST_STROBE);
    is_dma   = (kind == CYC_DMA_IN) || (kind == CYC_DMA_OUT);
    p_even     = in_cycle & lat[LAT_EVEN];
    p_odd      = in_cycle & lat[LAT_ODD];
    p_io_read  = strobing & ((kind == CYC_IO_READ) || (kind == CYC_DMA_IN));
    p_io_write = strobing & ((kind == CYC_IO_WRITE) || (kind == CYC_DMA_OUT));
    // terminal count rides on oe for dma write (card to memory), on we for dma read
    p_oe       = strobing & ((kind == CYC_MEM_READ) || (kind == CYC_DMA_IN && lat[LAT_LAST]));
    p_we       = strobing & ((kind == CYC_MEM_WRITE) || (kind == CYC_DMA_OUT && lat[LAT_LAST]));
    p_attr     = in_cycle & (is_dma | lat[LAT_ATTR]);
  end

  // pins come from flops; idle level is high
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      card_enable_even_n <= STROBE_IDLE;
      card_enable_odd_n  <= STROBE_IDLE;
      io_read_strobe_n   <= STROBE_IDLE;
      io_write_strobe_n  <= STROBE_IDLE;
      output_enable_n    <= STROBE_IDLE;
      write_enable_n     <= STROBE_IDLE;
      attr_select_n      <= STROBE_IDLE;
    end else begin
      card_enable_even_n <= p_even ? STROBE_ACTIVE : STROBE_IDLE;
      card_enable_odd_n  <= p_odd  ? STROBE_ACTIVE : STROBE_IDLE;
      io_read_strobe_n   <= p_io_read  ? STROBE_ACTIVE : STROBE_IDLE;
      io_write_strobe_n  <= p_io_write ? STROBE_ACTIVE : STROBE_IDLE;
      output_enable_n    <= p_oe   ? STROBE_ACTIVE : STROBE_IDLE;
      write_enable_n     <= p_we   ? STROBE_ACTIVE : STROBE_IDLE;
      attr_select_n      <= p_attr ? STROBE_ACTIVE : STROBE_IDLE;
    end
  end
endmodule : card_strobe_ctrl

// [verif/card_strobe_ctrl_assertions.sv]
// concurrent checks on the card strobe sequencer ports
`timescale 1ns/1ps
module card_strobe_ctrl_assertions
  import card_strobe_pkg::*;
#(
  parameter int SETUP_CNT  = SETUP_CYCLES,
  parameter int STROBE_CNT = STROBE_CYCLES,
  parameter int HOLD_CNT   = HOLD_CYCLES
) (
  input wire logic        clock, rst, req_valid, req_ready, req_even, req_odd, req_last, done,
  input wire cycle_kind_t req_kind,
  input wire logic        memory_only_mode, dma_enable, card_ready, card_irq, dma_request,
  input wire logic        card_enable_even_n, card_enable_odd_n, io_read_strobe_n, io_write_strobe_n,
  input wire logic        output_enable_n, write_enable_n, attr_select_n, input_ack_n, ready_irq_pin, wait_n
);
  localparam int D_PRE = SETUP_CNT + 1;
  localparam int D_STR = SETUP_CNT + 2;
  localparam int D_END = SETUP_CNT + STROBE_CNT + HOLD_CNT;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // pins lag the state by one stage, so strobe checks start at setup plus two
  wire take = req_valid && req_ready;
  wire rd   = !io_read_strobe_n;
  wire wr   = !io_write_strobe_n;
  wire oe   = !output_enable_n;
  wire we   = !write_enable_n;
  ////////////////////////////////////////////////////////////////////////////
  a_idle_strobes: assert property (req_ready |-> !rd && !wr && !oe && !we) else $error("strobe low while idle");
  a_rw_apart: assert property (!(rd && wr) && !(oe && we)) else $error("read and write strobes together");
  a_lane_enables: assert property (take |-> ##2 card_enable_even_n == !$past(req_even, 2)
    && card_enable_odd_n == !$past(req_odd, 2)) else $error("byte lane enables wrong");
  a_io_read_strobe: assert property (take && req_kind == CYC_IO_READ |-> ##D_PRE !rd ##1 rd)
    else $error("io read strobe late or missing");
  a_io_write_strobe: assert property (take && req_kind == CYC_IO_WRITE |-> ##D_PRE !wr ##1 wr)
    else $error("io write strobe late or missing");
  a_mem_read_oe: assert property (take && req_kind == CYC_MEM_READ |-> ##D_STR oe)
    else $error("output enable missing");
  a_dma_in_count: assert property (take && req_kind == CYC_DMA_IN && req_last |-> ##D_STR rd && oe && !attr_select_n)
    else $error("dma in strobe, count or ack missing");
  a_dma_out_count: assert property (take && req_kind == CYC_DMA_OUT && req_last |-> ##D_STR wr && we && !attr_select_n)
    else $error("dma out strobe, count or ack missing");
  a_done_short: assert property (done |-> !$past(req_ready, D_END)) else $error("cycle ended too soon");
  a_wait_holds: assert property ((!wait_n) [*4] ##0 rd |=> rd) else $error("strobe ended during wait");
  a_ready_level: assert property ((memory_only_mode && ready_irq_pin) [*3] |-> card_ready && !card_irq)
    else $error("ready not reported");
  a_irq_level: assert property ((!memory_only_mode && !ready_irq_pin) [*3] |-> card_irq && !card_ready)
    else $error("irq not reported");
  a_dma_request: assert property ((dma_enable && !input_ack_n) [*3] |-> dma_request)
    else $error("dma request not reported");
  // main scenarios reached
  c_dma_in: cover property (take && req_kind == CYC_DMA_IN);
  c_wait: cover property (!wait_n && rd);
  c_irq: cover property (card_irq);
endmodule : card_strobe_ctrl_assertions

// [verif/card_model.sv]
// behavioural 16-bit card answering the controller strobes
`timescale 1ns/1ps
module card_model (
  input  wire logic clock,             // system clock
  input  wire logic io_read_strobe_n,  // read strobe from controller
  input  wire logic io_write_strobe_n, // write strobe from controller
  input  wire logic slow,              // stretch strobes with wait
  input  wire logic answer,            // card claims io reads
  input  wire logic status_low,        // busy in memory mode, irq in io mode
  input  wire logic dma_req,           // ask for a dma transfer
  output logic      input_ack_n,       // ack or dma request
  output logic      ready_irq_pin,     // ready or irq line
  output logic      wait_n             // cycle stretch
);
  logic [4:0] cnt = 5'h00;
  wire        strobe = !io_read_strobe_n || !io_write_strobe_n;
  // count strobe cycles so a slow card lets go of wait after twenty
  always_ff @(posedge clock) cnt <= strobe ? cnt + 5'(cnt != 5'h1f) : 5'h00;
  assign wait_n        = !(slow && strobe && cnt < 5'h14);
  assign input_ack_n   = !(dma_req || (answer && !io_read_strobe_n));
  assign ready_irq_pin = !status_low;
endmodule : card_model

// [verif/card_strobe_ctrl_tb.sv]
// self-checking bench for the card strobe sequencer
`timescale 1ns/1ps
module card_strobe_ctrl_tb;
  import card_strobe_pkg::*;
  logic        clock = 0, rst = 1, req_valid = 0, req_attr = 0, req_even = 0, req_odd = 0, req_last = 0;
  logic        memory_only_mode = 0, dma_enable = 0, slow = 0, answer = 0, status_low = 0, dma_req = 0;
  cycle_kind_t req_kind = CYC_MEM_READ;
  logic        req_ready, done, done_input_ack, card_ready, card_irq, dma_request, input_ack_n, ready_irq_pin;
  logic        card_enable_even_n, card_enable_odd_n, io_read_strobe_n, io_write_strobe_n, wait_n;
  logic        output_enable_n, write_enable_n, attr_select_n;
  int          n_mismatch = 0, cmp_count = 0;
  wire  [6:0]  pins = {card_enable_even_n, card_enable_odd_n, io_read_strobe_n, io_write_strobe_n,
                       output_enable_n, write_enable_n, attr_select_n};
  card_strobe_ctrl i_card_strobe_ctrl (.*);
  card_model       i_card_model (.*);
  always #5 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one card cycle; f = even, odd, last, attr; pins that went low are gathered
  task automatic cyc(input cycle_kind_t k, input logic [3:0] f, input logic [6:0] e, input logic a, input int lo, hi);
    logic [6:0] low;
    int         n;
    low = 7'h00;
    n = 0;
    @(posedge clock);
    req_valid <= 1;
    req_kind <= k;
    {req_even, req_odd, req_last, req_attr} <= f;
    @(posedge clock);
    req_valid <= 0;
    do begin
      @(negedge clock);
      low |= ~pins;
      n++;
    end while (done !== 1'b1 && n < 200);
    chk("pins", {1'b0, e}, {1'b0, low});
    chk("ack", {7'h00, a}, {7'h00, done_input_ack});
    chk("length", 8'h01, {7'h00, n >= lo && n <= hi});
  endtask : cyc
  task automatic t_mem;
    cyc(CYC_MEM_READ, 4'h8, 7'h44, 0, 16, 16);
    cyc(CYC_MEM_WRITE, 4'h5, 7'h23, 0, 16, 16);
  endtask : t_mem
  task automatic t_io;
    answer <= 1;
    cyc(CYC_IO_READ, 4'hd, 7'h71, 1, 16, 16);
    answer <= 0;
    cyc(CYC_IO_READ, 4'h8, 7'h50, 0, 16, 16);
    cyc(CYC_IO_WRITE, 4'h8, 7'h48, 0, 16, 16);
  endtask : t_io
  task automatic t_dma;
    cyc(CYC_DMA_IN, 4'he, 7'h75, 0, 16, 16);
    cyc(CYC_DMA_IN, 4'hc, 7'h71, 0, 16, 16);
    cyc(CYC_DMA_OUT, 4'he, 7'h6b, 0, 16, 16);
  endtask : t_dma
  task automatic t_wait;
    slow <= 1;
    cyc(CYC_IO_WRITE, 4'h8, 7'h48, 0, 26, 60);
    cyc(CYC_IO_READ, 4'h8, 7'h50, 0, 26, 60);
    slow <= 0;
  endtask : t_wait
  // status lines need the two-stage synchroniser to settle
  task automatic t_status(input logic m, input logic s, input logic d, input logic [2:0] e);
    @(posedge clock);
    memory_only_mode <= m;
    status_low <= s;
    dma_enable <= d;
    dma_req <= d;
    repeat (4) @(posedge clock);
    @(negedge clock);
    chk("status", {5'h00, e}, {5'h00, card_ready, card_irq, dma_request});
  endtask : t_status
  task automatic end_sim;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clock);
    rst <= 0;
    t_mem();
    t_io();
    t_dma();
    t_wait();
    t_status(1, 1, 0, 3'h0);
    t_status(1, 0, 0, 3'h4);
    t_status(0, 1, 1, 3'h3);
    t_status(0, 0, 0, 3'h0);
    end_sim();
  end
  // well above the roughly 220 cycles the scenarios take
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    end_sim();
  end
endmodule : card_strobe_ctrl_tb
bind card_strobe_ctrl card_strobe_ctrl_assertions #(.SETUP_CNT(SETUP_CNT), .STROBE_CNT(STROBE_CNT),
  .HOLD_CNT(HOLD_CNT)) i_chk (.*);
